// ### design/adc_mux_ref_control.sv
/*
  Converter mux, reference and sequencing control with an AHB-Lite register
  slave. Assumes hclk is the converter clock and the analogue core returns a
  10-bit result sampled on the last cycle of each conversion.
*/
// Overview of operation
// - Reference drives output pin only while converter enabled.
// - Output pin high impedance unless enabled; 01 gives 1.1V, 11 gives 2.56V.
// - Reference: supply or external pin by ext_ref_enable, internal 1.1V or 2.56V by select bits.
// - Reference select change during conversion waits for completion.
// - Conversion after any reference select change takes 25 clocks.
// - Left-align bit changes result presentation immediately.
// - Channel and gain change during conversion waits for completion.
// - Codes 0-10 single-ended pins; 11 temp, 12 bandgap, 13 supply/4, 14 ground.
// - Top bit set selects differential pairs; lowest bit picks gain 8x or 20x.
// - Enable one turns converter on; zero turns off and aborts conversion.
// - Start bit begins each single conversion, only the first when free running.
// - First conversion after enabling lasts 25 clocks and initialises.
// - Start bit reads one while converting, cleared by hardware when done.
// - Writing zero to start bit is ignored.
// - Done flag set when conversion finishes and result updated.
// - Left-aligned: high byte bits 9..2; right-aligned: high byte bits 9..8 low.
`timescale 1ns/1ps
module adc_mux_ref_control
  import conv_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_ref_enable,
  input wire logic ref_out_enable,
  input wire logic [9:0] conv_result,
  output conv_ctrl_pkg::analog_ctrl_t analog_ctrl,
  output logic converter_on,
  output logic sampling,
  output logic ref_out_pin_o,
  output logic ref_out_pin_oe,
  output logic irq
);
  import conv_ctrl_pkg::*;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_IDLE = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;

  conv_state_t state_r, state_nxt;
  logic [7:0] mux_sel_r, mux_sel_nxt;
  logic [7:0] mux_act_r, mux_act_nxt;
  logic [7:0] csr_r, csr_nxt;
  logic [9:0] result_r;
  logic [4:0] cnt_r, cnt_nxt;
  logic first_r, first_nxt;
  logic ref_chg_r, ref_chg_nxt;
  logic irq_stat_r, irq_mask_r;
  logic ext_ref_s1_r, ext_ref_r, ref_out_s1_r, ref_out_r;
  logic wr_pend_r, rd_pend_r;
  logic [7:0] addr_r;
  analog_ctrl_t ana_nxt;

  // Bus decode
  wire addr_ph = hsel & hready & htrans[1];
  wire wr_mux = wr_pend_r & (addr_r == MUX_SELECT_ADDR);
  wire wr_csr = wr_pend_r & (addr_r == CTRL_STATUS_A_ADDR);
  wire wr_mask = wr_pend_r & (addr_r == IRQ_MASK_ADDR);
  wire rd_stat = rd_pend_r & (addr_r == IRQ_STATUS_ADDR);
  wire [7:0] wdata8 = hwdata[7:0];

  wire en_now = csr_r[ENABLE_BIT];
  wire en_wr = wdata8[ENABLE_BIT];
  wire start_req = wr_csr & en_wr & wdata8[START_BIT];
  wire busy = (state_r == ST_CONV);
  wire conv_end = busy & (cnt_r == 5'd1);

  // Read data sees the next values of all registers but the mask, so a read right behind a
  // write or a conversion end returns current data (bar a mask read behind a mask write) and does not lose the status event
  wire res_take = conv_end & ~(wr_csr & ~en_wr);
  wire [9:0] result_nxt = res_take ? conv_result : result_r;
  wire irq_stat_nxt = res_take | (irq_stat_r & ~rd_stat);
  wire busy_nxt = (state_nxt == ST_CONV);
  wire [7:0] res_hi = mux_sel_nxt[LEFT_ALIGN_BIT] ? result_nxt[9:2] : {6'h00, result_nxt[9:8]};
  wire [7:0] res_lo = mux_sel_nxt[LEFT_ALIGN_BIT] ? {result_nxt[1:0], 6'h00} : result_nxt[7:0];
  wire [7:0] csr_view = {csr_nxt[7], busy_nxt, csr_nxt[5:0]};

  wire [31:0] rd_mux = {24'h000000, mux_sel_nxt};
  wire [31:0] rd_csr = {24'h000000, csr_view};
  wire [31:0] rd_res = {16'h0000, res_hi, res_lo};
  wire [31:0] rd_irq = {31'h00000000, irq_stat_nxt};
  wire [31:0] rd_msk = {31'h00000000, irq_mask_r};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rdata_nxt = (ra == MUX_SELECT_ADDR) ? rd_mux :
                          (ra == CTRL_STATUS_A_ADDR) ? rd_csr :
                          (ra == RESULT_ADDR) ? rd_res :
                          (ra == IRQ_STATUS_ADDR) ? rd_irq :
                          (ra == IRQ_MASK_ADDR) ? rd_msk : 32'h00000000;

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    first_nxt = first_r;
    mux_act_nxt = mux_act_r;
    ref_chg_nxt = ref_chg_r;
    csr_nxt = csr_r;
    mux_sel_nxt = mux_sel_r;
    if (wr_mux) begin
      mux_sel_nxt = wdata8;
      if (wdata8[7:6] != mux_sel_r[7:6]) begin
        ref_chg_nxt = 1'b1;
      end
    end
    if (wr_csr) begin
      // Done flag write-one-to-clear; start bit is not stored and reads back as busy
      csr_nxt = {wdata8[7], 1'b0, wdata8[5], csr_r[4] & ~wdata8[4], wdata8[3:0]};
    end
    if (!busy) begin
      mux_act_nxt = mux_sel_nxt;
    end
    unique case (state_r)
      ST_OFF: begin
        first_nxt = 1'b1;
        if (wr_csr & en_wr) begin
          state_nxt = ST_IDLE;
        end
        if (start_req) begin
          state_nxt = ST_CONV;
          cnt_nxt = LONG_CYCLES;
        end
      end
      ST_IDLE: begin
        if (wr_csr & ~en_wr) begin
          state_nxt = ST_OFF;
        end else if (start_req) begin
          state_nxt = ST_CONV;
          cnt_nxt = (first_r | ref_chg_r) ? LONG_CYCLES : NORMAL_CYCLES;
        end
      end
      ST_CONV: begin
        if (wr_csr & ~en_wr) begin
          state_nxt = ST_OFF;
        end else if (conv_end) begin
          csr_nxt[DONE_FLAG_BIT] = 1'b1;
          first_nxt = 1'b0;
          ref_chg_nxt = (mux_sel_nxt[7:6] != mux_act_r[7:6]) | (wr_mux & (wdata8[7:6] != mux_sel_r[7:6]));
          mux_act_nxt = mux_sel_nxt;
          if (csr_nxt[FREE_RUN_BIT]) begin
            cnt_nxt = (mux_sel_nxt[7:6] != mux_act_r[7:6]) ? LONG_CYCLES : NORMAL_CYCLES;
            ref_chg_nxt = 1'b0;
          end else begin
            state_nxt = ST_IDLE;
          end
        end else begin
          cnt_nxt = cnt_r - 5'd1;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // Reference and channel decode for the analogue core
  always_comb begin
    ana_nxt = '0;
    ana_nxt.init_cycle = first_r & busy;
    unique case ({mux_act_r[REF_SELECT_LSB], ext_ref_r})
      2'b00: ana_nxt.ref_source = REF_SUPPLY;
      2'b01: ana_nxt.ref_source = REF_EXTERNAL;
      2'b10: ana_nxt.ref_source = mux_act_r[7] ? REF_INTERNAL_HIGH : REF_INTERNAL_LOW;
      default: ana_nxt.ref_source = REF_ILLEGAL;
    endcase
    if (mux_act_r[4]) begin
      ana_nxt.source = SRC_DIFF;
      ana_nxt.gain_high = mux_act_r[0];
      // Pairs skip inputs 3 and 7 as positive terminals
      ana_nxt.pos_input = {1'b0, mux_act_r[3:1]} + {3'b000, (mux_act_r[3:1] >= 3'd3)}
                          + {3'b000, (mux_act_r[3:1] >= 3'd6)};
      ana_nxt.neg_input = ana_nxt.pos_input + 4'd1;
    end else if (mux_act_r[3:0] <= SEL_LAST_PIN[3:0]) begin
      ana_nxt.source = SRC_PIN;
      ana_nxt.pos_input = mux_act_r[3:0];
    end else begin
      unique case (mux_act_r[4:0])
        SEL_TEMP: ana_nxt.source = SRC_TEMP;
        SEL_BANDGAP: ana_nxt.source = SRC_BANDGAP;
        SEL_SUPPLY_QUARTER: ana_nxt.source = SRC_SUPPLY_QUARTER;
        SEL_GROUND: ana_nxt.source = SRC_GROUND;
        default: ana_nxt.source = SRC_RESERVED;
      endcase
    end
  end

  wire ref_drive = csr_nxt[ENABLE_BIT] & ref_out_r & mux_act_nxt[REF_SELECT_LSB] & ~ext_ref_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_OFF;
      cnt_r <= 5'd0;
      first_r <= 1'b1;
      ref_chg_r <= 1'b0;
      mux_sel_r <= MUX_SELECT_RESET;
      mux_act_r <= MUX_SELECT_RESET;
      csr_r <= CTRL_STATUS_A_RESET;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      first_r <= first_nxt;
      ref_chg_r <= ref_chg_nxt;
      mux_sel_r <= mux_sel_nxt;
      mux_act_r <= mux_act_nxt;
      csr_r <= csr_nxt;
    end
  end

  // Result capture and interrupt; the set beats the read-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_r <= 10'h000;
      irq_stat_r <= 1'b0;
      irq_mask_r <= 1'b0;
    end else if (clk_en) begin
      if (conv_end && !(wr_csr && !en_wr)) begin
        result_r <= conv_result;
      end
      irq_stat_r <= (conv_end & ~(wr_csr & ~en_wr)) | (irq_stat_r & ~rd_stat);
      if (wr_mask) begin
        irq_mask_r <= wdata8[0];
      end
    end
  end

  // Pin-side enables pass two flops; only the second is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_ref_s1_r <= 1'b0;
      ext_ref_r <= 1'b0;
      ref_out_s1_r <= 1'b0;
      ref_out_r <= 1'b0;
    end else if (clk_en) begin
      ext_ref_s1_r <= ext_ref_enable;
      ext_ref_r <= ext_ref_s1_r;
      ref_out_s1_r <= ref_out_enable;
      ref_out_r <= ref_out_s1_r;
    end
  end

  // Zero-wait slave: read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (clk_en) begin
      wr_pend_r <= addr_ph & hwrite;
      rd_pend_r <= addr_ph & ~hwrite;
      addr_r <= haddr[7:0];
      if (addr_ph && !hwrite) begin
        hrdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      analog_ctrl <= '0;
      converter_on <= 1'b0;
      sampling <= 1'b0;
      ref_out_pin_o <= 1'b0;
      ref_out_pin_oe <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      analog_ctrl <= ana_nxt;
      converter_on <= csr_nxt[ENABLE_BIT];
      sampling <= (state_nxt == ST_CONV);
      ref_out_pin_o <= ref_drive;
      ref_out_pin_oe <= ref_drive;
      irq <= ((conv_end & ~(wr_csr & ~en_wr)) | (irq_stat_r & ~rd_stat)) & (wr_mask ? wdata8[0] : irq_mask_r);
    end
  end

endmodule : adc_mux_ref_control

// ### design/conv_ctrl_pkg.sv
/*
  Package for the converter mux/reference control block: register offsets,
  field positions, reset values, cycle counts, selector codes and carriers.
  Assumes a 32-bit AHB-Lite slave with one aligned word per register.
*/
package conv_ctrl_pkg;

  // Register byte addresses
  localparam logic [7:0] MUX_SELECT_ADDR = 8'h00;
  localparam logic [7:0] CTRL_STATUS_A_ADDR = 8'h04;
  localparam logic [7:0] RESULT_ADDR = 8'h08;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;

  localparam logic [7:0] MUX_SELECT_RESET = 8'h00;
  localparam logic [7:0] CTRL_STATUS_A_RESET = 8'h00;

  // Field positions in converter_mux_select
  localparam int REF_SELECT_LSB = 6;
  localparam int LEFT_ALIGN_BIT = 5;
  localparam int GAIN_SELECT_LSB = 0;
  // Field positions in converter_control_status_a
  localparam int ENABLE_BIT = 7;
  localparam int START_BIT = 6;
  localparam int FREE_RUN_BIT = 5;
  localparam int DONE_FLAG_BIT = 4;

  // Conversion lengths in converter clocks
  localparam logic [4:0] NORMAL_CYCLES = 5'd13;
  localparam logic [4:0] LONG_CYCLES = 5'd25;

  localparam logic [1:0] REF_INT_LOW = 2'b01;
  localparam logic [1:0] REF_INT_HIGH = 2'b11;

  localparam logic [4:0] SEL_LAST_PIN = 5'h0A;
  localparam logic [4:0] SEL_TEMP = 5'h0B;
  localparam logic [4:0] SEL_BANDGAP = 5'h0C;
  localparam logic [4:0] SEL_SUPPLY_QUARTER = 5'h0D;
  localparam logic [4:0] SEL_GROUND = 5'h0E;

  typedef enum logic [2:0] {
    REF_SUPPLY = 3'h0,
    REF_EXTERNAL = 3'h1,
    REF_INTERNAL_LOW = 3'h2,
    REF_INTERNAL_HIGH = 3'h3,
    REF_ILLEGAL = 3'h4
  } ref_source_t;

  typedef enum logic [3:0] {
    SRC_PIN = 4'h0,
    SRC_DIFF = 4'h1,
    SRC_TEMP = 4'h2,
    SRC_BANDGAP = 4'h3,
    SRC_SUPPLY_QUARTER = 4'h4,
    SRC_GROUND = 4'h5,
    SRC_RESERVED = 4'h6
  } input_source_t;

  // Settings handed to the analogue core
  typedef struct packed {
    ref_source_t ref_source;
    input_source_t source;
    logic [3:0] pos_input;
    logic [3:0] neg_input;
    logic gain_high;
    logic init_cycle;
  } analog_ctrl_t;

endpackage : conv_ctrl_pkg

// ### tb/adc_ctrl_checker_assertions.sv
/* Port checker for the converter control block.
   Assumes clk_en is held high and one clock domain. */
`timescale 1ns/1ps
module adc_ctrl_checker
  import conv_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ext_ref_enable,
  input wire logic ref_out_enable,
  input wire conv_ctrl_pkg::analog_ctrl_t analog_ctrl,
  input wire logic converter_on,
  input wire logic sampling,
  input wire logic ref_out_pin_oe
);
  logic [5:0] run_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      run_r <= 6'h00;
    else
      run_r <= sampling ? run_r + 6'h01 : 6'h00;
  end
  sequence s_ref_off; !ref_out_enable [*6]; endsequence
  sequence s_ext_on; ext_ref_enable [*6]; endsequence
  sequence s_end; $fell(sampling) && converter_on; endsequence
  property p_oe_on; ref_out_pin_oe |-> converter_on || $past(converter_on); endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin driven while off");
  property p_ref_off; s_ref_off |-> !ref_out_pin_oe; endproperty
  a_ref_off: assert property (p_ref_off) else $error("pin driven without enable");
  property p_ext_on; s_ext_on |-> !ref_out_pin_oe; endproperty
  a_ext_on: assert property (p_ext_on) else $error("pin driven with ext ref");
  property p_run_on; sampling |-> converter_on || $past(converter_on); endproperty
  a_run_on: assert property (p_run_on) else $error("sampling while off");
  property p_abort; $fell(converter_on) |-> ##[0:1] !sampling; endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");
  property p_len; s_end |-> run_r == 6'h0D || run_r == 6'h19; endproperty
  a_len: assert property (p_len) else $error("bad conversion length");
  property p_hold; sampling && run_r >= 6'h02 && run_r <= 6'h0C |-> $stable(analog_ctrl[16:1]); endproperty
  a_hold: assert property (p_hold) else $error("selection moved mid conversion");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or error");
endmodule : adc_ctrl_checker
bind adc_mux_ref_control adc_ctrl_checker u_chk (.hclk, .hresetn, .hreadyout, .hresp, .ext_ref_enable,
  .ref_out_enable, .analog_ctrl, .converter_on, .sampling, .ref_out_pin_oe);

// ### tb/analog_core_model.sv
/* Analogue core model: code from the applied selection while sampling.
   Assumes the block samples the result inside the conversion. */
`timescale 1ns/1ps
module analog_core_model
  import conv_ctrl_pkg::*;
(
  input wire conv_ctrl_pkg::analog_ctrl_t analog_ctrl,
  input wire logic sampling,
  output logic [9:0] conv_result
);
  logic [9:0] code;
  assign code = {analog_ctrl.source[1:0], analog_ctrl.pos_input, ~analog_ctrl.pos_input};
  // Inverted outside conversions so an early sample is caught
  assign conv_result = sampling ? code : ~code;
endmodule : analog_core_model

// ### tb/tb_top.sv
/* Self-checking bench: AHB-Lite master tasks and scenarios.
   Assumes the analogue model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
  import conv_ctrl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic ext_ref_enable = 1'b0;
  logic ref_out_enable = 1'b0;
  logic hreadyout, hresp, converter_on, sampling, oe, irq;
  logic [31:0] hrdata;
  logic [9:0] conv_result;
  analog_ctrl_t actl;
  int errors = 0;
  int comparisons = 0;
  int n;
  adc_mux_ref_control u_dut (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_ref_enable, .ref_out_enable, .conv_result,
    .analog_ctrl(actl), .converter_on, .sampling, .ref_out_pin_o(), .ref_out_pin_oe(oe), .irq);
  analog_core_model u_core (.analog_ctrl(actl), .sampling, .conv_result);
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Reads compare against e; writes ignore it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e = 0);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w) chk("read", e, hrdata);
  endtask : bus
  task automatic go(input logic [7:0] c);
    bus(1'b1, CTRL_STATUS_A_ADDR, {24'h0, c});
    while (sampling !== 1'b1) @(posedge hclk);
  endtask : go
  task automatic fin();
    n = 0;
    while (sampling === 1'b1) begin
      @(posedge hclk);
      n++;
    end
    // Registered selection outputs settle one edge after the end
    @(posedge hclk);
  endtask : fin
  task automatic t_basic();
    bus(1'b0, MUX_SELECT_ADDR, 0, 32'h0);
    bus(1'b0, CTRL_STATUS_A_ADDR, 0, 32'h0);
    bus(1'b1, 8'h20, 32'hFF);
    bus(1'b0, 8'h20, 0, 32'h0);
    bus(1'b1, MUX_SELECT_ADDR, 32'h05);
    go(8'hC0);
    fin();
    chk("first_len", 32'h19, n);
    bus(1'b0, RESULT_ADDR, 0, 32'h05A);
    bus(1'b0, CTRL_STATUS_A_ADDR, 0, 32'h90);
    bus(1'b1, MUX_SELECT_ADDR, 32'h25);
    bus(1'b0, RESULT_ADDR, 0, 32'h1680);
    go(8'hC0);
    bus(1'b0, CTRL_STATUS_A_ADDR, 0, 32'hD0);
    bus(1'b1, CTRL_STATUS_A_ADDR, 32'h80);
    fin();
    chk("start0_len", 32'h09, n);
  endtask : t_basic
  task automatic t_ref();
    logic [1:0] sel [4] = '{2'h3, 2'h0, 2'h1, 2'h0};
    logic ext [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    ref_source_t es [4] = '{REF_INTERNAL_HIGH, REF_EXTERNAL, REF_INTERNAL_LOW, REF_SUPPLY};
    go(8'hC0);
    bus(1'b1, MUX_SELECT_ADDR, 32'h43);
    chk("ref_held", REF_SUPPLY, actl.ref_source);
    chk("mux_held", 32'h5, actl.pos_input);
    fin();
    chk("mux_new", 32'h3, actl.pos_input);
    for (int i = 0; i < 4; i++) begin
      ext_ref_enable <= ext[i];
      ref_out_enable <= sel[i][0];
      repeat (4) @(posedge hclk);
      bus(1'b1, MUX_SELECT_ADDR, {24'h0, sel[i], 6'h03});
      go(8'hC0);
      fin();
      chk("ref_len", 32'h19, n);
      chk("ref_src", es[i], actl.ref_source);
      chk("ref_pin", sel[i][0], oe);
    end
    bus(1'b1, MUX_SELECT_ADDR, 32'h43);
    ref_out_enable <= 1'b1;
    go(8'hC0);
    bus(1'b1, CTRL_STATUS_A_ADDR, 32'h00);
    repeat (2) @(posedge hclk);
    chk("aborted", 0, sampling);
    chk("pin_off", 0, oe);
    ref_out_enable <= 1'b0;
    go(8'hC0);
    fin();
    chk("reinit_len", 32'h19, n);
  endtask : t_ref
  task automatic t_codes();
    logic [3:0] pair [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
    logic [4:0] c;
    input_source_t es;
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      es = c[4] ? SRC_DIFF : c <= 5'h0A ? SRC_PIN : c == 5'h0F ? SRC_RESERVED : input_source_t'(c - 5'h09);
      bus(1'b1, MUX_SELECT_ADDR, {27'h0, c});
      go(8'hC0);
      fin();
      chk("src", es, actl.source);
      if (c[4]) begin
        chk("pos", pair[c[3:1]], actl.pos_input);
        chk("neg", pair[c[3:1]] + 4'h1, actl.neg_input);
        chk("gain", c[0], actl.gain_high);
      end else if (c <= 5'h0A) begin
        chk("pin", c, actl.pos_input);
      end
    end
  endtask : t_codes
  task automatic t_irq();
    bus(1'b0, IRQ_STATUS_ADDR, 0, 32'h1);
    bus(1'b1, IRQ_MASK_ADDR, 32'h1);
    go(8'hC0);
    fin();
    repeat (2) @(posedge hclk);
    chk("irq_on", 1, irq);
    bus(1'b0, IRQ_STATUS_ADDR, 0, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_clr", 0, irq);
    bus(1'b1, IRQ_MASK_ADDR, 32'h0);
    go(8'hE0);
    repeat (20) @(posedge hclk);
    chk("free_run", 1, sampling);
    chk("irq_masked", 0, irq);
    bus(1'b1, CTRL_STATUS_A_ADDR, 32'h00);
  endtask : t_irq
  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_basic();
    t_ref();
    t_codes();
    t_irq();
    end_sim();
  end
  initial begin
    #100us;
    errors++;
    end_sim();
  end
endmodule : tb_top
